// ==== rtl/quart_pkg.sv ====
// Shared constants and carrier types of the four-channel serial front end.
package quart_pkg;

	localparam int NCH   = 4;
	localparam int LVL_W = 7;

	// Channel register indices, address bits 3:0 with bits 7 and 6 low.
	localparam logic [3:0] REG_DIV_LO  = 4'h0;
	localparam logic [3:0] REG_DIV_HI  = 4'h1;
	localparam logic [3:0] REG_FCR     = 4'h2;
	localparam logic [3:0] REG_MCR     = 4'h3;
	localparam logic [3:0] REG_SRS     = 4'h4;
	localparam logic [3:0] REG_TX_TRIG = 4'h5;
	localparam logic [3:0] REG_RX_TRIG = 4'h6;
	localparam logic [3:0] REG_IEN     = 4'h7;
	localparam logic [3:0] REG_STAT    = 4'h8;

	// Device-wide register indices, address bit 7 high.
	localparam logic [7:0] GLB_RESET = 8'h80;
	localparam logic [7:0] GLB_BCAST = 8'h81;
	localparam logic [7:0] GLB_IRQ   = 8'h82;

	// Field positions.
	localparam int FCR_FIFO_EN = 0;
	localparam int FCR_HDX     = 1;
	localparam int MCR_IR      = 6;
	localparam int MCR_PRESC   = 7;
	localparam int IEN_TX      = 0;
	localparam int IEN_RX      = 1;
	localparam int BCAST_EN    = 0;

	// Reset values and counts.
	localparam logic [15:0]      DIV_RST     = 16'h0000;
	localparam logic [7:0]       FCR_RST     = 8'h00;
	localparam logic [7:0]       MCR_RST     = 8'h00;
	localparam logic [LVL_W-1:0] TRIG_RST    = 7'h08;
	localparam logic [1:0]       IEN_RST     = 2'h0;
	localparam logic [1:0]       PRESC_LAST  = 2'h3;
	localparam logic [3:0]       OVS16_LAST  = 4'hf;
	localparam logic [3:0]       OVS8_LAST   = 4'h7;
	localparam logic [1:0]       RESP_OKAY   = 2'h0;
	localparam logic [1:0]       RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [15:0]      div;
		logic [7:0]       fifo_control_reg;
		logic [7:0]       modem_control_reg;
		logic             srs;
		logic [LVL_W-1:0] tx_trig;
		logic [LVL_W-1:0] rx_trig;
		logic [1:0]       ien;
	} chan_cfg_t;

	localparam chan_cfg_t CFG_RST = '{div: DIV_RST, fifo_control_reg: FCR_RST, modem_control_reg: MCR_RST, srs: 1'b0,
		tx_trig: TRIG_RST, rx_trig: TRIG_RST, ien: IEN_RST};

	typedef struct packed {
		logic [LVL_W-1:0] tx_level;
		logic [LVL_W-1:0] rx_level;
		logic             tx_idle;
	} chan_lvl_t;

	typedef struct packed {
		chan_cfg_t [NCH-1:0] cfg;
		logic [NCH-1:0][1:0]  presc;
		logic [NCH-1:0][15:0] bcnt;
		logic [NCH-1:0][3:0]  bitcnt;
		logic [NCH-1:0]       tick;
		logic [NCH-1:0]       bit_tick;
		logic [NCH-1:0]       tx_int;
		logic [NCH-1:0]       rx_int;
		logic [NCH-1:0]       strap_load;
		logic                 bcast;
		logic                 irq_n;
		logic                 awready;
		logic                 wready;
		logic                 arready;
		logic                 aw_got;
		logic                 w_got;
		logic [9:0]           awaddr;
		logic [7:0]           wdata;
		logic                 wstrb0;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
	} state_t;

endpackage : quart_pkg

// ==== rtl/quart_front.sv ====
// Four-channel serial front end: select, broadcast, resets, interrupt levels, baud generators.
//
// Function
// - Hardware reset returns registers and serial outputs of all four channels to defaults.
// - Writing the software reset register resets registers of the selected channels.
// - The host accesses the device only while selecting it; here each bus access.
// - With address bit 7 low, bits 5:4 pick channel 0 to 3.
// - With broadcast bit 0 set, a channel write updates that register everywhere.
// - FIFO on, half duplex off: transmit level high above trigger, low below or empty.
// - FIFO on, half duplex on: high above trigger, low below or transmitter empty.
// - FIFO on: receive level high below trigger, low above trigger.
// - One system clock runs every baud generator and all other logic.
// - Prescaler divides by four when modem control bit 7 set, else by one.
// - Baud generator divides prescaled clock by a 16-bit divisor, 1 to 65535.
// - Sampling-rate select picks 16 or 8 sample ticks per bit.
// - Divisor is split into high and low byte registers.
// - One sampling tick per channel times both transmit and receive.
// - After any reset the strap level is copied into modem control bit 6.
`timescale 1ns/1ns

module quart_front #(
	parameter int AXI_ADDR_W = 12
) (
	// Clock and reset.
	input  wire logic                                  aclk,
	input  wire logic                                  aresetn,
	// AXI4-Lite write channels.
	input  wire logic [AXI_ADDR_W-1:0]                 awaddr,
	input  wire logic                                  awvalid,
	output logic                                       awready,
	input  wire logic [31:0]                           wdata,
	input  wire logic [3:0]                            wstrb,
	input  wire logic                                  wvalid,
	output logic                                       wready,
	output logic [1:0]                                 bresp,
	output logic                                       bvalid,
	input  wire logic                                  bready,
	// AXI4-Lite read channels.
	input  wire logic [AXI_ADDR_W-1:0]                 araddr,
	input  wire logic                                  arvalid,
	output logic                                       arready,
	output logic [31:0]                                rdata,
	output logic [1:0]                                 rresp,
	output logic                                       rvalid,
	input  wire logic                                  rready,
	// Channel FIFO levels and strap.
	input  wire quart_pkg::chan_lvl_t [quart_pkg::NCH-1:0] lvl,
	input  wire logic                                  infrared_startup_strap,
	// Channel outputs.
	output logic [quart_pkg::NCH-1:0]                  sample_tick,
	output logic [quart_pkg::NCH-1:0]                  bit_tick,
	output logic [quart_pkg::NCH-1:0]                  tx_int,
	output logic [quart_pkg::NCH-1:0]                  rx_int,
	output logic [quart_pkg::NCH-1:0]                  infrared_mode,
	output logic                                       irq_n
);

	if (AXI_ADDR_W < 10) begin : g_addr_check
		$error("AXI_ADDR_W must be at least 10.");
	end

	////////////////////////////////////////////////////////////////////////////////////////////////

	quart_pkg::state_t r;
	quart_pkg::state_t s_nxt;
	logic              wr_fire;
	logic [7:0]        wr_idx;
	logic [7:0]        rd_idx;
	logic [quart_pkg::NCH-1:0] pend;

	function automatic logic idx_ok(input logic [7:0] idx);
		idx_ok = (!idx[7] && !idx[6] && idx[3:0] <= quart_pkg::REG_STAT)
			|| idx == quart_pkg::GLB_RESET || idx == quart_pkg::GLB_BCAST
			|| idx == quart_pkg::GLB_IRQ;
	endfunction : idx_ok

	////////////////////////////////////////////////////////////////////////////////////////////////

	// Next-state logic, all on the one system clock.
	always_comb begin
		logic ptick;
		logic [3:0] last;
		logic hit;
		ptick = 1'b0;
		last = quart_pkg::OVS16_LAST;
		hit = 1'b0;
		s_nxt = r;
		wr_fire = r.aw_got && r.w_got && !r.bvalid;
		wr_idx = r.awaddr[9:2];
		rd_idx = araddr[9:2];
		pend = '0;
		for (int c = 0; c < quart_pkg::NCH; c++) begin
			// Strap copy after any reset.
			if (r.strap_load[c]) begin
				s_nxt.cfg[c].modem_control_reg[quart_pkg::MCR_IR] = infrared_startup_strap;
				s_nxt.strap_load[c] = 1'b0;
			end
			// Prescaler.
			if (r.cfg[c].modem_control_reg[quart_pkg::MCR_PRESC]) begin
				s_nxt.presc[c] = r.presc[c] + 2'h1;
				ptick = r.presc[c] == quart_pkg::PRESC_LAST;
			end else begin
				s_nxt.presc[c] = 2'h0;
				ptick = 1'b1;
			end
			// Divisor counter; a zero divisor stops the ticks.
			s_nxt.tick[c] = 1'b0;
			if (r.cfg[c].div == 16'h0000) begin
				s_nxt.bcnt[c] = 16'h0000;
			end else if (ptick) begin
				if (r.bcnt[c] >= r.cfg[c].div - 16'h0001) begin
					s_nxt.bcnt[c] = 16'h0000;
					s_nxt.tick[c] = 1'b1;
				end else begin
					s_nxt.bcnt[c] = r.bcnt[c] + 16'h0001;
				end
			end
			// Bit tick after 16 or 8 sample ticks, shared by both directions.
			last = r.cfg[c].srs ? quart_pkg::OVS8_LAST : quart_pkg::OVS16_LAST;
			s_nxt.bit_tick[c] = 1'b0;
			if (r.tick[c]) begin
				if (r.bitcnt[c] >= last) begin
					s_nxt.bitcnt[c] = 4'h0;
					s_nxt.bit_tick[c] = 1'b1;
				end else begin
					s_nxt.bitcnt[c] = r.bitcnt[c] + 4'h1;
				end
			end
			// Transmit and receive interrupt levels.
			if (r.cfg[c].fifo_control_reg[quart_pkg::FCR_FIFO_EN]) begin
				if (lvl[c].tx_level > r.cfg[c].tx_trig) begin
					s_nxt.tx_int[c] = 1'b1;
				end else if (lvl[c].tx_level < r.cfg[c].tx_trig) begin
					s_nxt.tx_int[c] = 1'b0;
				end else if (r.cfg[c].fifo_control_reg[quart_pkg::FCR_HDX] ? lvl[c].tx_idle
						: lvl[c].tx_level == '0) begin
					s_nxt.tx_int[c] = 1'b0;
				end
				if (lvl[c].rx_level < r.cfg[c].rx_trig) begin
					s_nxt.rx_int[c] = 1'b1;
				end else if (lvl[c].rx_level > r.cfg[c].rx_trig) begin
					s_nxt.rx_int[c] = 1'b0;
				end
			end else begin
				s_nxt.tx_int[c] = 1'b1;
				s_nxt.rx_int[c] = 1'b1;
			end
			pend[c] = (r.cfg[c].ien[quart_pkg::IEN_TX] && !r.tx_int[c])
				|| (r.cfg[c].ien[quart_pkg::IEN_RX] && !r.rx_int[c]);
		end
		s_nxt.irq_n = ~|pend;

		// Write address and data are taken in either order; each access selects the device.
		if (awvalid && r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = awaddr[9:0];
		end
		if (wvalid && r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = wdata[7:0];
			s_nxt.wstrb0 = wstrb[0];
		end
		if (bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (wr_fire) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = quart_pkg::RESP_OKAY;
			if (r.awaddr[1:0] != 2'h0 || !idx_ok(wr_idx)) begin
				s_nxt.bresp = quart_pkg::RESP_SLVERR;
			end else if (r.wstrb0) begin
				if (!wr_idx[7]) begin
					for (int c = 0; c < quart_pkg::NCH; c++) begin
						hit = r.bcast || wr_idx[5:4] == 2'(c);
						if (hit) begin
							case (wr_idx[3:0])
								quart_pkg::REG_DIV_LO: s_nxt.cfg[c].div[7:0] = r.wdata;
								quart_pkg::REG_DIV_HI: s_nxt.cfg[c].div[15:8] = r.wdata;
								quart_pkg::REG_FCR: s_nxt.cfg[c].fifo_control_reg = r.wdata;
								quart_pkg::REG_MCR: s_nxt.cfg[c].modem_control_reg = r.wdata;
								quart_pkg::REG_SRS: s_nxt.cfg[c].srs = r.wdata[0];
								quart_pkg::REG_TX_TRIG: s_nxt.cfg[c].tx_trig = r.wdata[6:0];
								quart_pkg::REG_RX_TRIG: s_nxt.cfg[c].rx_trig = r.wdata[6:0];
								quart_pkg::REG_IEN: s_nxt.cfg[c].ien = r.wdata[1:0];
								default: s_nxt.cfg[c] = s_nxt.cfg[c];
							endcase
						end
					end
				end else if (wr_idx == quart_pkg::GLB_BCAST) begin
					s_nxt.bcast = r.wdata[quart_pkg::BCAST_EN];
				end else if (wr_idx == quart_pkg::GLB_RESET) begin
					for (int c = 0; c < quart_pkg::NCH; c++) begin
						if (r.wdata[c]) begin
							s_nxt.cfg[c] = quart_pkg::CFG_RST;
							s_nxt.presc[c] = 2'h0;
							s_nxt.bcnt[c] = 16'h0000;
							s_nxt.bitcnt[c] = 4'h0;
							s_nxt.tick[c] = 1'b0;
							s_nxt.bit_tick[c] = 1'b0;
							s_nxt.tx_int[c] = 1'b1;
							s_nxt.rx_int[c] = 1'b1;
							s_nxt.strap_load[c] = 1'b1;
						end
					end
				end
			end
		end

		// Read channel: one answer per address, held until taken.
		if (rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = quart_pkg::RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			if (araddr[1:0] != 2'h0 || !idx_ok(rd_idx)) begin
				s_nxt.rresp = quart_pkg::RESP_SLVERR;
			end else if (!rd_idx[7]) begin
				case (rd_idx[3:0])
					quart_pkg::REG_DIV_LO: s_nxt.rdata[7:0] = r.cfg[rd_idx[5:4]].div[7:0];
					quart_pkg::REG_DIV_HI: s_nxt.rdata[7:0] = r.cfg[rd_idx[5:4]].div[15:8];
					quart_pkg::REG_FCR: s_nxt.rdata[7:0] = r.cfg[rd_idx[5:4]].fifo_control_reg;
					quart_pkg::REG_MCR: s_nxt.rdata[7:0] = r.cfg[rd_idx[5:4]].modem_control_reg;
					quart_pkg::REG_SRS: s_nxt.rdata[0] = r.cfg[rd_idx[5:4]].srs;
					quart_pkg::REG_TX_TRIG: s_nxt.rdata[6:0] = r.cfg[rd_idx[5:4]].tx_trig;
					quart_pkg::REG_RX_TRIG: s_nxt.rdata[6:0] = r.cfg[rd_idx[5:4]].rx_trig;
					quart_pkg::REG_IEN: s_nxt.rdata[1:0] = r.cfg[rd_idx[5:4]].ien;
					default: s_nxt.rdata[2:0] = {lvl[rd_idx[5:4]].tx_idle,
						r.rx_int[rd_idx[5:4]], r.tx_int[rd_idx[5:4]]};
				endcase
			end else if (rd_idx == quart_pkg::GLB_BCAST) begin
				s_nxt.rdata[0] = r.bcast;
			end else if (rd_idx == quart_pkg::GLB_IRQ) begin
				s_nxt.rdata[quart_pkg::NCH-1:0] = pend;
			end
		end

		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
	end

	////////////////////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.cfg <= {quart_pkg::NCH{quart_pkg::CFG_RST}};
			r.tx_int <= '1;
			r.rx_int <= '1;
			r.strap_load <= '1;
			r.irq_n <= 1'b1;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
		end else begin
			r <= s_nxt;
		end
	end

	assign awready = r.awready;
	assign wready = r.wready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = r.arready;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign sample_tick = r.tick;
	assign bit_tick = r.bit_tick;
	assign tx_int = r.tx_int;
	assign rx_int = r.rx_int;
	assign irq_n = r.irq_n;

	for (genvar c = 0; c < quart_pkg::NCH; c++) begin : g_ir
		assign infrared_mode[c] = r.cfg[c].modem_control_reg[quart_pkg::MCR_IR];
	end

	////////////////////////////////////////////////////////////////////////////////////////////////

	// Checks.
	a_hw_reset_cfg: assert property (@(posedge aclk) !aresetn |=>
		r.cfg[3] == quart_pkg::CFG_RST && r.tick == '0 && irq_n)
		else $error("Hardware reset left channel state.");

	a_soft_reset_ch: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && r.wstrb0 && r.awaddr[1:0] == 2'h0 && wr_idx == quart_pkg::GLB_RESET
		&& r.wdata[2] |=> r.cfg[2] == quart_pkg::CFG_RST)
		else $error("Software reset missed channel.");

	a_chan_select: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && r.wstrb0 && !r.bcast && r.awaddr[1:0] == 2'h0 && wr_idx == 8'h25
		|=> r.cfg[2].tx_trig == $past(r.wdata[6:0]) && $stable(r.cfg[0].tx_trig))
		else $error("Channel select wrong.");

	a_broadcast_wr: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && r.wstrb0 && r.bcast && r.awaddr[1:0] == 2'h0 && wr_idx[7:6] == 2'h0
		&& wr_idx[3:0] == quart_pkg::REG_RX_TRIG |=> r.cfg[0].rx_trig == $past(r.wdata[6:0])
		&& r.cfg[3].rx_trig == $past(r.wdata[6:0]))
		else $error("Broadcast write incomplete.");

	a_tx_int_empty: assert property (@(posedge aclk) disable iff (!aresetn)
		r.cfg[0].fifo_control_reg[1:0] == 2'h1 && lvl[0].tx_level == '0 |=> !tx_int[0])
		else $error("Transmit level high on empty FIFO.");

	a_tx_int_hdx: assert property (@(posedge aclk) disable iff (!aresetn)
		r.cfg[0].fifo_control_reg[1:0] == 2'h3 && lvl[0].tx_level > r.cfg[0].tx_trig |=> tx_int[0])
		else $error("Transmit level low above trigger.");

	a_rx_int_below: assert property (@(posedge aclk) disable iff (!aresetn)
		r.cfg[0].fifo_control_reg[0] && lvl[0].rx_level < r.cfg[0].rx_trig |=> rx_int[0])
		else $error("Receive level low below trigger.");

	a_presc_div4: assert property (@(posedge aclk) disable iff (!aresetn)
		r.tick[3] && r.cfg[3].modem_control_reg[7] && !r.aw_got && !awvalid |=> !r.tick[3] [*3])
		else $error("Prescaler period not four.");

	a_divisor_period: assert property (@(posedge aclk) disable iff (!aresetn)
		r.tick[3] && !r.cfg[3].modem_control_reg[7] && r.cfg[3].div == 16'h0003 && !r.aw_got && !awvalid
		|=> !r.tick[3] [*2] ##1 r.tick[3])
		else $error("Divisor period wrong.");

	a_bit_tick_src: assert property (@(posedge aclk) disable iff (!aresetn)
		r.tick[3] && !wr_fire && r.bitcnt[3] == (r.cfg[3].srs ? quart_pkg::OVS8_LAST
		: quart_pkg::OVS16_LAST) |=> bit_tick[3])
		else $error("Bit tick count wrong.");

	a_strap_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		r.strap_load[1] |=> infrared_mode[1] == $past(infrared_startup_strap))
		else $error("Strap not copied.");

	a_irq_any: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> irq_n == ($past(pend) == '0))
		else $error("Interrupt output mismatch.");

	c_broadcast: cover property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && r.bcast && !wr_idx[7]);
	c_soft_reset: cover property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_idx == quart_pkg::GLB_RESET);
	c_presc_tick: cover property (@(posedge aclk) disable iff (!aresetn)
		r.tick[3] && r.cfg[3].modem_control_reg[7]);
	c_irq_low: cover property (@(posedge aclk) disable iff (!aresetn) !irq_n);

endmodule : quart_front

// ==== dv/quart_chan_model.sv ====
// Channel-side model that holds the FIFO levels seen by the front end.
`timescale 1ns/1ns

module quart_chan_model (
	// Clock.
	input  wire logic                                 aclk,
	// Channel levels.
	output quart_pkg::chan_lvl_t [quart_pkg::NCH-1:0] lvl
);

	initial lvl = '0;

	// Levels move just after a clock edge, as real FIFO counters do.
	task automatic set_lvl(input int ch, input logic [6:0] tx, input logic [6:0] rx,
		input logic idle);
		@(posedge aclk);
		lvl[ch] <= {tx, rx, idle};
	endtask : set_lvl

endmodule : quart_chan_model

// ==== dv/test_quart_front.sv ====
// Self-checking bench for the four-channel serial front end.
`timescale 1ns/1ns

module test_quart_front;

	localparam logic [1:0]  OK    = quart_pkg::RESP_OKAY;
	localparam logic [1:0]  ERR   = quart_pkg::RESP_SLVERR;
	localparam logic [11:0] A_RST = {2'b00, quart_pkg::GLB_RESET, 2'b00};
	localparam logic [11:0] A_BC  = {2'b00, quart_pkg::GLB_BCAST, 2'b00};
	localparam logic [11:0] A_IRQ = {2'b00, quart_pkg::GLB_IRQ, 2'b00};

	logic                                     aclk = 1'b0;
	logic                                     aresetn = 1'b0;
	logic [11:0]                              awaddr = 12'h000;
	logic [11:0]                              araddr = 12'h000;
	logic [31:0]                              wdata = 32'h00000000;
	logic [31:0]                              rdata;
	logic                                     awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                                     arvalid = 1'b0, rready = 1'b0, strap = 1'b1;
	logic                                     awready, wready, bvalid, arready, rvalid, irq_n;
	logic [1:0]                               bresp, rresp;
	logic [3:0]                               sample_tick, bit_tick, tx_int, rx_int, infrared_mode;
	quart_pkg::chan_lvl_t [quart_pkg::NCH-1:0] lvl;
	int                                       error_cnt = 0;
	int                                       checked = 0;
	int                                       cyc = 0;

	always #5 aclk = ~aclk;

	quart_chan_model chan (
		.aclk (aclk),
		.lvl  (lvl)
	);

	quart_front #(.AXI_ADDR_W(12)) uut (
		.aclk                   (aclk),
		.aresetn                (aresetn),
		.awaddr                 (awaddr),
		.awvalid                (awvalid),
		.awready                (awready),
		.wdata                  (wdata),
		.wstrb                  (4'h1),
		.wvalid                 (wvalid),
		.wready                 (wready),
		.bresp                  (bresp),
		.bvalid                 (bvalid),
		.bready                 (bready),
		.araddr                 (araddr),
		.arvalid                (arvalid),
		.arready                (arready),
		.rdata                  (rdata),
		.rresp                  (rresp),
		.rvalid                 (rvalid),
		.rready                 (rready),
		.lvl                    (lvl),
		.infrared_startup_strap (strap),
		.sample_tick            (sample_tick),
		.bit_tick               (bit_tick),
		.tx_int                 (tx_int),
		.rx_int                 (rx_int),
		.infrared_mode          (infrared_mode),
		.irq_n                  (irq_n)
	);

	////////////////////////////////////////////////////////////////////////////////

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic t_end(input string name);
		$display("test %s finished", name);
	endtask : t_end

	function automatic logic [11:0] ca(input int c, input logic [3:0] r);
		return {4'h0, 2'(c), r, 2'b00};
	endfunction : ca

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, exp);
		chk(32'(rresp), 32'(er));
	endtask : rd

	task automatic lv(input int ch, input logic [6:0] tx, input logic [6:0] rx, input logic idle);
		chan.set_lvl(ch, tx, rx, idle);
		repeat (3) @(posedge aclk);
	endtask : lv

	// Counts the cycles between two pulses after skipping two periods, the first possibly partial.
	task automatic per(input int ch, input logic bt, input int exp);
		int n;
		repeat (2) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while ((bt ? bit_tick[ch] : sample_tick[ch]) !== 1'b1 && n < 3000);
		end
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while ((bt ? bit_tick[ch] : sample_tick[ch]) !== 1'b1 && n < 3000);
		chk(32'(n), 32'(exp));
	endtask : per

	////////////////////////////////////////////////////////////////////////////////

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ca(0, quart_pkg::REG_DIV_LO), 32'h0, OK);
		rd(ca(1, quart_pkg::REG_TX_TRIG), 32'h8, OK);
		rd(ca(2, quart_pkg::REG_MCR), 32'h40, OK);
		rd(ca(3, quart_pkg::REG_STAT), 32'h3, OK);
		chk(32'(infrared_mode), 32'hf);
		t_end("reset");
		for (int c = 0; c < 4; c++) wr(ca(c, quart_pkg::REG_TX_TRIG), 8'(c + 16), OK);
		for (int c = 0; c < 4; c++) rd(ca(c, quart_pkg::REG_TX_TRIG), 32'(c + 16), OK);
		rd(12'h20c, 32'h0, ERR);
		rd(12'h100, 32'h0, ERR);
		wr(ca(0, 4'h9), 8'h11, ERR);
		t_end("select");
		wr(A_BC, 8'h01, OK);
		wr(ca(1, quart_pkg::REG_RX_TRIG), 8'h20, OK);
		wr(A_BC, 8'h00, OK);
		for (int c = 0; c < 4; c++) rd(ca(c, quart_pkg::REG_RX_TRIG), 32'h20, OK);
		t_end("broadcast");
		strap <= 1'b0;
		wr(A_RST, 8'h04, OK);
		rd(ca(2, quart_pkg::REG_RX_TRIG), 32'h8, OK);
		rd(ca(1, quart_pkg::REG_RX_TRIG), 32'h20, OK);
		chk(32'(infrared_mode), 32'hb);
		t_end("soft reset");
		wr(ca(0, quart_pkg::REG_FCR), 8'h01, OK);
		wr(ca(0, quart_pkg::REG_TX_TRIG), 8'h00, OK);
		lv(0, 7'd5, 7'd2, 1'b0);
		chk(32'(tx_int[0]), 32'h1);
		chk(32'(rx_int[0]), 32'h1);
		lv(0, 7'd0, 7'd2, 1'b0);
		chk(32'(tx_int[0]), 32'h0);
		lv(0, 7'd5, 7'd2, 1'b0);
		wr(ca(0, quart_pkg::REG_FCR), 8'h03, OK);
		lv(0, 7'd0, 7'd2, 1'b0);
		chk(32'(tx_int[0]), 32'h1);
		lv(0, 7'd0, 7'd2, 1'b1);
		chk(32'(tx_int[0]), 32'h0);
		wr(ca(0, quart_pkg::REG_IEN), 8'h02, OK);
		chk(32'(irq_n), 32'h1);
		lv(0, 7'd0, 7'd40, 1'b1);
		chk(32'(rx_int[0]), 32'h0);
		chk(32'(irq_n), 32'h0);
		rd(A_IRQ, 32'h1, OK);
		t_end("interrupt");
		wr(ca(3, quart_pkg::REG_DIV_LO), 8'h03, OK);
		wr(ca(3, quart_pkg::REG_DIV_HI), 8'h00, OK);
		per(3, 1'b0, 3);
		per(3, 1'b1, 48);
		wr(ca(3, quart_pkg::REG_MCR), 8'h80, OK);
		per(3, 1'b0, 12);
		wr(ca(3, quart_pkg::REG_SRS), 8'h01, OK);
		per(3, 1'b1, 96);
		wr(ca(3, quart_pkg::REG_MCR), 8'h00, OK);
		wr(ca(3, quart_pkg::REG_DIV_HI), 8'h01, OK);
		wr(ca(3, quart_pkg::REG_DIV_LO), 8'h02, OK);
		per(3, 1'b0, 258);
		t_end("baud");
		test_done();
	end

endmodule : test_quart_front
